// >>> logic/pdbc_consts.vh
// Constants of the power-down and output buffer control register bank.
// Included by every design file of the bank; definitions only.
`ifndef PDBC_CONSTS_VH
`define PDBC_CONSTS_VH

`define PDBC_ADDR_W          8
`define PDBC_DATA_W          8
`define PDBC_OFF_POWER       8'h08
`define PDBC_OFF_OBUF_LOW    8'h0A
`define PDBC_OFF_OBUF_MID    8'h0B
`define PDBC_OFF_OBUF_HIGH   8'h0C
`define PDBC_OFF_SLEEP_MASK  8'h0D
`define PDBC_RESET_VALUE     8'h00

// Power control fields
`define PDBC_PWR_CLKBUF_BIT  5
`define PDBC_PWR_REFERENCE_GAIN_AMP_BIT  4
`define PDBC_PWR_CHA_BIT     2
`define PDBC_PWR_CHB_BIT     1
`define PDBC_PWR_GLOBAL_BIT  0

// Global sleep mask fields
`define PDBC_MSK_CLKBUF_BIT  3
`define PDBC_MSK_REFERENCE_GAIN_AMP_BIT  2
`define PDBC_MSK_BANDGAP_BIT 1

// Output buffer disable bit positions inside their registers
`define PDBC_LOW_B5_BIT      7
`define PDBC_LOW_B4_BIT      6
`define PDBC_LOW_B2_BIT      4
`define PDBC_LOW_B1_BIT      3
`define PDBC_LOW_B0_BIT      2
`define PDBC_MID_A4_BIT      7
`define PDBC_MID_A2_BIT      5
`define PDBC_MID_A1_BIT      4
`define PDBC_MID_A0_BIT      3
`define PDBC_MID_B6_BIT      0
`define PDBC_HIGH_A3_BIT     3
`define PDBC_HIGH_B3_BIT     2
`define PDBC_HIGH_A6_BIT     1
`define PDBC_HIGH_A5_BIT     0

`endif

// >>> logic/pdbc_reg8.v
// One 8-bit read-write configuration register with write strobe.
// Assumes a single clock domain and asynchronous active-low reset.
`timescale 1ns/1ps
`include "pdbc_consts.vh"

module pdbc_reg8 (
    input  wire       mclk_i,   // Device clock
    input  wire       nrst_i,   // Async reset, active low
    input  wire       wr_i,     // Write strobe, one cycle
    input  wire [7:0] wdata_i,  // Write data
    output reg  [7:0] q_o       // Stored value
);

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_o <= `PDBC_RESET_VALUE;
        end else if (wr_i) begin
            q_o <= wdata_i;
        end
    end

endmodule // pdbc_reg8

// >>> logic/pdbc_pin_map.v
// Maps the 14 output buffer disable bits onto per-pin buffer-off controls.
// Purely combinational; registered by the top module.
`timescale 1ns/1ps
`include "pdbc_consts.vh"

module pdbc_pin_map (
    input  wire [7:0] low_i,    // Buffer-off register, low
    input  wire [7:0] mid_i,    // Buffer-off register, mid
    input  wire [7:0] high_i,   // Buffer-off register, high
    output wire [6:0] cha_o,    // Channel A pin 6..0 buffer off
    output wire [6:0] chb_o     // Channel B pin 6..0 buffer off
);

    assign cha_o = {high_i[`PDBC_HIGH_A6_BIT], high_i[`PDBC_HIGH_A5_BIT], mid_i[`PDBC_MID_A4_BIT],
                    high_i[`PDBC_HIGH_A3_BIT], mid_i[`PDBC_MID_A2_BIT], mid_i[`PDBC_MID_A1_BIT],
                    mid_i[`PDBC_MID_A0_BIT]};
    assign chb_o = {mid_i[`PDBC_MID_B6_BIT], low_i[`PDBC_LOW_B5_BIT], low_i[`PDBC_LOW_B4_BIT],
                    high_i[`PDBC_HIGH_B3_BIT], low_i[`PDBC_LOW_B2_BIT], low_i[`PDBC_LOW_B1_BIT],
                    low_i[`PDBC_LOW_B0_BIT]};

endmodule // pdbc_pin_map

// >>> logic/pdbc_bank.v
// Power-down and output buffer control register bank of a dual-channel converter.
// Assumes a serial-port front end that delivers decoded byte writes and reads in the mclk_i domain.
//
// Behaviour
// - Power bit 5 turns off the sampling clock buffer; resets to zero.
// - Power bit 4 turns off the reference gain amplifier.
// - Power bit 2 turns off converter channel A.
// - Power bit 1 turns off converter channel B.
// - Power bit 0 requests global sleep; mask register at 0x0D selects affected blocks.
// - Fourteen buffer-off bits over three registers; one turns a pin buffer off.
// - Fixed mapping of buffer-off bits in output_buffer_off_low, output_buffer_off_mid, output_buffer_off_high to pins.
// - Buffer-off bits never touch incoming or outgoing data clock buffers.
// - Mask bit 3 zero lets global sleep stop the clock buffer.
// - Mask bit 2 zero lets global sleep stop the reference amplifier.
// - Mask bit 1 one lets global sleep stop the bandgap reference.
`timescale 1ns/1ps
`include "pdbc_consts.vh"

module pdbc_bank (
    input  wire       mclk_i,                // Device clock, 40 MHz
    input  wire       nrst_i,                // Async reset, active low
    input  wire       wr_i,                  // Register write strobe
    input  wire       rd_i,                  // Register read strobe
    input  wire [7:0] addr_i,                // Register address
    input  wire [7:0] wdata_i,               // Write data
    output reg  [7:0] rdata_o,               // Read data, registered
    output reg        rvalid_o,              // Read data valid pulse
    output reg        sample_clock_buffer_off_o, // Clock buffer powered down
    output reg        ref_amp_off_o,         // Reference gain amp powered down
    output reg        channel_a_off_o,       // Channel A powered down
    output reg        channel_b_off_o,       // Channel B powered down
    output reg        bandgap_off_o,         // Bandgap reference powered down
    output reg        global_sleep_o,        // Global sleep active
    output reg  [6:0] cha_pin_buffer_off_o,  // Channel A pin 6..0 buffers off
    output reg  [6:0] chb_pin_buffer_off_o   // Channel B pin 6..0 buffers off
);

    wire [7:0] power_reg;
    wire [7:0] obuf_low_reg;
    wire [7:0] obuf_mid_reg;
    wire [7:0] obuf_high_reg;
    wire [7:0] sleep_mask_reg;
    wire [6:0] cha_map;
    wire [6:0] chb_map;
    wire       global_req;
    reg  [7:0] rdata_next;

    // Address decode and write enables, one per mapped register
    wire       hit_power;
    wire       hit_obuf_low;
    wire       hit_obuf_mid;
    wire       hit_obuf_high;
    wire       hit_sleep_mask;
    wire       wr_power;
    wire       wr_obuf_low;
    wire       wr_obuf_mid;
    wire       wr_obuf_high;
    wire       wr_sleep_mask;

    // Single-bit views of the power and mask fields
    wire       pwr_clkbuf;
    wire       pwr_reference_gain_amp;
    wire       pwr_cha;
    wire       pwr_chb;
    wire       msk_clkbuf;
    wire       msk_reference_gain_amp;
    wire       msk_bandgap;

    // Next values of the registered outputs
    reg        rvalid_next;
    reg        clkbuf_off_next;
    reg        reference_gain_amp_off_next;
    reg        cha_off_next;
    reg        chb_off_next;
    reg        bandgap_off_next;
    reg        global_sleep_next;
    reg  [6:0] cha_pins_next;
    reg  [6:0] chb_pins_next;

    // Plain storage, reset to zero, read back as written
    pdbc_reg8 u_power (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .wr_i    (wr_power),
        .wdata_i (wdata_i),
        .q_o     (power_reg)
    );

    pdbc_reg8 u_obuf_low (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .wr_i    (wr_obuf_low),
        .wdata_i (wdata_i),
        .q_o     (obuf_low_reg)
    );

    pdbc_reg8 u_obuf_mid (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .wr_i    (wr_obuf_mid),
        .wdata_i (wdata_i),
        .q_o     (obuf_mid_reg)
    );

    pdbc_reg8 u_obuf_high (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .wr_i    (wr_obuf_high),
        .wdata_i (wdata_i),
        .q_o     (obuf_high_reg)
    );

    pdbc_reg8 u_sleep_mask (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .wr_i    (wr_sleep_mask),
        .wdata_i (wdata_i),
        .q_o     (sleep_mask_reg)
    );

    // Data clock buffers are not in this map; their enables live elsewhere
    pdbc_pin_map u_pin_map (
        .low_i   (obuf_low_reg),
        .mid_i   (obuf_mid_reg),
        .high_i  (obuf_high_reg),
        .cha_o   (cha_map),
        .chb_o   (chb_map)
    );

    assign global_req = power_reg[`PDBC_PWR_GLOBAL_BIT];

    // Address decode
    assign hit_power      = (addr_i == `PDBC_OFF_POWER);
    assign hit_obuf_low   = (addr_i == `PDBC_OFF_OBUF_LOW);
    assign hit_obuf_mid   = (addr_i == `PDBC_OFF_OBUF_MID);
    assign hit_obuf_high  = (addr_i == `PDBC_OFF_OBUF_HIGH);
    assign hit_sleep_mask = (addr_i == `PDBC_OFF_SLEEP_MASK);

    // Writes to unmapped addresses fall through and change nothing
    assign wr_power       = wr_i && hit_power;
    assign wr_obuf_low    = wr_i && hit_obuf_low;
    assign wr_obuf_mid    = wr_i && hit_obuf_mid;
    assign wr_obuf_high   = wr_i && hit_obuf_high;
    assign wr_sleep_mask  = wr_i && hit_sleep_mask;

    // Field views keep the power logic below readable
    assign pwr_clkbuf     = power_reg[`PDBC_PWR_CLKBUF_BIT];
    assign pwr_reference_gain_amp     = power_reg[`PDBC_PWR_REFERENCE_GAIN_AMP_BIT];
    assign pwr_cha        = power_reg[`PDBC_PWR_CHA_BIT];
    assign pwr_chb        = power_reg[`PDBC_PWR_CHB_BIT];
    assign msk_clkbuf     = sleep_mask_reg[`PDBC_MSK_CLKBUF_BIT];
    assign msk_reference_gain_amp     = sleep_mask_reg[`PDBC_MSK_REFERENCE_GAIN_AMP_BIT];
    assign msk_bandgap    = sleep_mask_reg[`PDBC_MSK_BANDGAP_BIT];

    // Reserved bits are stored too, so they read back whatever the host wrote
    always @* begin
        rdata_next = 8'h00;
        case (addr_i)
            `PDBC_OFF_POWER: begin
                rdata_next = power_reg;
            end
            `PDBC_OFF_OBUF_LOW: begin
                rdata_next = obuf_low_reg;
            end
            `PDBC_OFF_OBUF_MID: begin
                rdata_next = obuf_mid_reg;
            end
            `PDBC_OFF_OBUF_HIGH: begin
                rdata_next = obuf_high_reg;
            end
            `PDBC_OFF_SLEEP_MASK: begin
                rdata_next = sleep_mask_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // A block is off by its own bit, or by global sleep unless masked
    always @* begin
        clkbuf_off_next = 1'b0;
        if (pwr_clkbuf) begin
            clkbuf_off_next = 1'b1;
        end else if (global_req && !msk_clkbuf) begin
            clkbuf_off_next = 1'b1;
        end
    end

    always @* begin
        reference_gain_amp_off_next = 1'b0;
        if (pwr_reference_gain_amp) begin
            reference_gain_amp_off_next = 1'b1;
        end else if (global_req && !msk_reference_gain_amp) begin
            reference_gain_amp_off_next = 1'b1;
        end
    end

    // Global sleep stops both channels; the mask has no channel bits
    always @* begin
        cha_off_next = 1'b0;
        if (pwr_cha) begin
            cha_off_next = 1'b1;
        end else if (global_req) begin
            cha_off_next = 1'b1;
        end
    end

    always @* begin
        chb_off_next = 1'b0;
        if (pwr_chb) begin
            chb_off_next = 1'b1;
        end else if (global_req) begin
            chb_off_next = 1'b1;
        end
    end

    // Inverted sense: bandgap sleeps only when allowed, trading wake-up time
    always @* begin
        bandgap_off_next = 1'b0;
        if (global_req) begin
            if (msk_bandgap) begin
                bandgap_off_next = 1'b1;
            end
        end
    end

    // Global sleep flag follows the request bit
    always @* begin
        global_sleep_next = global_req;
    end

    // Read valid is the read strobe one flip-flop later
    always @* begin
        rvalid_next = rd_i;
    end

    // Pin maps pass straight through to their flip-flops
    always @* begin
        cha_pins_next = cha_map;
        chb_pins_next = chb_map;
    end

    // Read port: valid is a one-cycle pulse, data holds until the next read
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rvalid_next;
            if (rd_i) begin
                rdata_o <= rdata_next;
            end
        end
    end

    // Clock buffer, reference amplifier and bandgap controls
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sample_clock_buffer_off_o <= 1'b0;
            ref_amp_off_o             <= 1'b0;
            bandgap_off_o             <= 1'b0;
        end else begin
            sample_clock_buffer_off_o <= clkbuf_off_next;
            ref_amp_off_o             <= reference_gain_amp_off_next;
            bandgap_off_o             <= bandgap_off_next;
        end
    end

    // Channel controls and the global sleep flag
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            channel_a_off_o           <= 1'b0;
            channel_b_off_o           <= 1'b0;
            global_sleep_o            <= 1'b0;
        end else begin
            channel_a_off_o           <= cha_off_next;
            channel_b_off_o           <= chb_off_next;
            global_sleep_o            <= global_sleep_next;
        end
    end

    // Pin buffer controls; data clock buffers are not among them
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cha_pin_buffer_off_o <= 7'h00;
        end else begin
            cha_pin_buffer_off_o <= cha_pins_next;
        end
    end

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chb_pin_buffer_off_o <= 7'h00;
        end else begin
            chb_pin_buffer_off_o <= chb_pins_next;
        end
    end

endmodule // pdbc_bank

// >>> verif/pdbc_host.sv
// Host model driving byte writes and reads into the bank.
// Assumes one clock; requests change only at rising edges.
`timescale 1ns/1ps
module pdbc_host (
    input  wire       mclk_i,   // Device clock
    input  wire       rvalid_i, // Read data valid
    input  wire [7:0] rdata_i,  // Read data
    output reg        wr_o,     // Write strobe
    output reg        rd_o,     // Read strobe
    output reg  [7:0] addr_o,   // Address
    output reg  [7:0] wdata_o   // Write data
);
    initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
    function [7:0] rsv_clear(input [7:0] a, input [7:0] x);
        rsv_clear = x & (a == 8'h08 ? 8'h37 : a == 8'h0D ? 8'h0E : 8'hFF);
    endfunction
    // Released lines show the inverse so stale values cannot pass
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk_i);
            {wr_o, addr_o, wdata_o} <= {1'b1, a, rsv_clear(a, d)};
            @(posedge mclk_i);
            {wr_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            @(posedge mclk_i);
            {rd_o, addr_o} <= {1'b1, a};
            @(posedge mclk_i);
            {rd_o, addr_o} <= {1'b0, ~a};
            #1 {v, d} = {rvalid_i, rdata_i};
        end
    endtask
endmodule // pdbc_host

// >>> verif/pdbc_bank_properties.sv
// Timing checks on the bank ports.
// Assumes one clock and one-cycle strobes from the host.
`timescale 1ns/1ps
module pdbc_bank_properties (
    input wire mclk_i, nrst_i, wr_i, rd_i, rvalid_o, // Clock, reset, strobes
    input wire [7:0] addr_i, wdata_i, rdata_o,        // Register port
    input wire sample_clock_buffer_off_o, ref_amp_off_o, channel_a_off_o, // Controls
    input wire channel_b_off_o, bandgap_off_o, global_sleep_o,            // Controls
    input wire [6:0] chb_pin_buffer_off_o                                // Pin buffers
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Second cycle excludes an overwrite of the same register
    sequence s_wr(a, b);
        wr_i && addr_i == a && wdata_i[b] ##1 !(wr_i && addr_i == a);
    endsequence
    sequence s_zero;
        wr_i && addr_i == 8'h08 && wdata_i == 8'h00 ##1 !(wr_i && addr_i == 8'h08);
    endsequence
    // Mask bit b written as v, a cycle with no mask rewrite, then global sleep alone requested
    sequence s_masked_sleep(b, v);
        wr_i && addr_i == 8'h0D && wdata_i[b] == v ##1 !(wr_i && addr_i == 8'h0D)
            ##1 wr_i && addr_i == 8'h08 && wdata_i == 8'h01 ##1 !(wr_i && addr_i == 8'h08);
    endsequence
    property p_clkbuf; s_wr(8'h08, 5) |=> sample_clock_buffer_off_o; endproperty
    property p_reference_gain_amp; s_wr(8'h08, 4) |=> ref_amp_off_o; endproperty
    property p_cha; s_wr(8'h08, 2) |=> channel_a_off_o; endproperty
    property p_chb; s_wr(8'h08, 1) |=> channel_b_off_o; endproperty
    property p_global; s_wr(8'h08, 0) |=> global_sleep_o && channel_a_off_o && channel_b_off_o; endproperty
    property p_bandgap; bandgap_off_o |-> global_sleep_o; endproperty
    property p_pin; s_wr(8'h0A, 3) |=> chb_pin_buffer_off_o[1]; endproperty
    property p_rvalid; rd_i |=> rvalid_o; endproperty
    property p_unmapped; rd_i && addr_i == 8'h09 |=> rdata_o == 8'h00; endproperty
    property p_clear;
        s_zero |=> !(sample_clock_buffer_off_o | ref_amp_off_o | channel_a_off_o | channel_b_off_o
                     | bandgap_off_o | global_sleep_o);
    endproperty
    property p_clkbuf_kept; s_masked_sleep(3, 1'b1) |=> !sample_clock_buffer_off_o; endproperty
    property p_clkbuf_sleep; s_masked_sleep(3, 1'b0) |=> sample_clock_buffer_off_o; endproperty
    property p_reference_gain_amp_kept; s_masked_sleep(2, 1'b1) |=> !ref_amp_off_o; endproperty
    property p_bandgap_kept; s_masked_sleep(1, 1'b0) |=> !bandgap_off_o; endproperty
    property p_bandgap_sleep; s_masked_sleep(1, 1'b1) |=> bandgap_off_o; endproperty
    property p_rvalid_pulse; !rd_i |=> !rvalid_o; endproperty
    property p_rdata_hold; !rd_i |=> $stable(rdata_o); endproperty
    a_clkbuf: assert property (p_clkbuf) else $error("clock buffer stays on");
    a_reference_gain_amp: assert property (p_reference_gain_amp) else $error("ref amp stays on");
    a_cha: assert property (p_cha) else $error("channel a stays on");
    a_chb: assert property (p_chb) else $error("channel b stays on");
    a_global: assert property (p_global) else $error("global sleep missing");
    a_bandgap: assert property (p_bandgap) else $error("bandgap off without sleep");
    a_pin: assert property (p_pin) else $error("pin buffer stays on");
    a_rvalid: assert property (p_rvalid) else $error("no read valid");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_clear: assert property (p_clear) else $error("controls not cleared");
    a_clkbuf_kept: assert property (p_clkbuf_kept) else $error("masked clock buffer slept");
    a_clkbuf_sleep: assert property (p_clkbuf_sleep) else $error("unmasked clock buffer on");
    a_reference_gain_amp_kept: assert property (p_reference_gain_amp_kept) else $error("masked ref amp slept");
    a_bandgap_kept: assert property (p_bandgap_kept) else $error("bandgap slept unallowed");
    a_bandgap_sleep: assert property (p_bandgap_sleep) else $error("allowed bandgap stays on");
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid too long");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
endmodule // pdbc_bank_properties
bind pdbc_bank pdbc_bank_properties pdbc_bank_properties_inst (.mclk_i, .nrst_i, .wr_i, .rd_i,
    .rvalid_o, .addr_i, .wdata_i, .rdata_o, .sample_clock_buffer_off_o, .ref_amp_off_o, .channel_a_off_o,
    .channel_b_off_o, .bandgap_off_o, .global_sleep_o, .chb_pin_buffer_off_o);

// >>> verif/tb_pdbc_bank.sv
// Self-checking bench of the power and buffer control bank.
// Assumes the host model in pdbc_host and the bound checker.
`timescale 1ns/1ps
module tb_pdbc_bank;
    reg        mclk_i = 1'b0, nrst_i = 1'b0;
    wire       wr_i, rd_i, rvalid_o, sample_clock_buffer_off_o, ref_amp_off_o;
    wire       channel_a_off_o, channel_b_off_o, bandgap_off_o, global_sleep_o;
    wire [7:0] addr_i, wdata_i, rdata_o;
    wire [6:0] cha_pin_buffer_off_o, chb_pin_buffer_off_o;
    integer    errors = 0, total_checks = 0, i, k;
    reg [15:0] rnd = 16'h7E9C;
    reg [7:0]  sh [0:5], ad [0:5], md [0:11], d;
    reg        v;
    pdbc_bank pdbc_bank_inst (.mclk_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
        .sample_clock_buffer_off_o, .ref_amp_off_o, .channel_a_off_o, .channel_b_off_o, .bandgap_off_o,
        .global_sleep_o, .cha_pin_buffer_off_o, .chb_pin_buffer_off_o);
    pdbc_host pdbc_host_inst (.mclk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i),
        .addr_o(addr_i), .wdata_o(wdata_i));
    initial forever #12.5 mclk_i = ~mclk_i;
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [19:0] expv();
        expv = {sh[0][5] | sh[0][0] & ~sh[4][3], sh[0][4] | sh[0][0] & ~sh[4][2], sh[0][2] | sh[0][0],
                sh[0][1] | sh[0][0], sh[0][0] & sh[4][1], sh[0][0], sh[3][1], sh[3][0], sh[2][7],
                sh[3][3], sh[2][5], sh[2][4], sh[2][3], sh[2][0], sh[1][7], sh[1][6], sh[3][2],
                sh[1][4], sh[1][3], sh[1][2]};
    endfunction
    task chk(input [19:0] g, input [19:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
            end
        end
    endtask
    task put(input integer j, input [7:0] x);
        begin
            pdbc_host_inst.wr(ad[j], x);
            sh[j] = pdbc_host_inst.rsv_clear(ad[j], x);
        end
    endtask
    task rbk(input integer j);
        begin
            pdbc_host_inst.rd(ad[j], d, v);
            chk({11'h0, v, d}, {11'h1, sh[j]});
        end
    endtask
    task outs;
        begin
            repeat (2) @(posedge mclk_i);
            #1 chk({sample_clock_buffer_off_o, ref_amp_off_o, channel_a_off_o, channel_b_off_o, bandgap_off_o,
                    global_sleep_o, cha_pin_buffer_off_o, chb_pin_buffer_off_o}, expv());
        end
    endtask
    task do_reset;
        begin
            nrst_i <= 1'b0;
            repeat (8) @(posedge mclk_i);
            nrst_i <= 1'b1;
            for (k = 0; k < 6; k = k + 1) sh[k] = 8'h00;
            for (k = 0; k < 6; k = k + 1) rbk(k);
            outs;
            $display("test reset done");
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        {ad[0], ad[1], ad[2], ad[3], ad[4], ad[5]} = 48'h080A0B0C0D09;
        {md[0], md[1], md[2], md[3], md[4], md[5], md[6], md[7], md[8], md[9], md[10], md[11]} =
            96'h2346F07FEEFCFFEEFDFFEFFD;
        do_reset;
        for (i = 0; i < 60; i = i + 1) begin
            rnd = lfsr(rnd);
            k = rnd[10:8] % 5;
            put(k, rnd[7:0]);
            if (rnd[11]) rbk(k);
            // Skipping the settle check leaves writes back to back when rnd[11] also skips the readback
            if (rnd[12]) outs;
        end
        $display("test random done");
        for (i = 0; i < 2; i = i + 1) begin
            put(4, i ? 8'h0E : 8'h00);
            put(0, 8'h01);
            outs;
        end
        put(0, 8'h00);
        outs;
        for (i = 0; i < 4; i = i + 1) begin
            for (k = 1; k < 4; k = k + 1) put(k, md[3 * i + k - 1]);
            outs;
            if (i > 0) chk({19'h0, chb_pin_buffer_off_o[1]}, 20'h1);
        end
        $display("test modes done");
        pdbc_host_inst.wr(8'h09, 8'hFF);
        rbk(5);
        outs;
        do_reset;
        tally_and_finish;
    end
    initial begin
        #400000;
        errors = errors + 1;
        tally_and_finish;
    end
endmodule // tb_pdbc_bank
